/* File: position_compare_pkg.sv */
// constants, types and object map of the position compare output unit
// assumes every host-written object arrives as a level on the core clock
package position_compare_pkg;

  // object indices of the fieldbus dictionary
  localparam logic [15:0] OBJ_COMPARE_CONTROL_WORD  = 16'h30b0;
  localparam logic [15:0] OBJ_POSITION_ADJUST_VALUE = 16'h30b1;
  localparam logic [15:0] OBJ_COMPARE_STATUS_WORD   = 16'h30c0;
  localparam logic [15:0] OBJ_CURRENT_POINT_INDEX   = 16'h30c1;
  localparam logic [15:0] OBJ_CURRENT_POSITION      = 16'h30c2;

  // control and status word bit positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_ORIGIN = 1;
  localparam int BIT_ADJUST = 2;

  // field encodings
  localparam logic MODE_ABSOLUTE    = 1'b0;
  localparam logic MODE_INCREMENTAL = 1'b1;
  localparam logic RUN_SINGLE       = 1'b0;
  localparam logic RUN_CYCLIC       = 1'b1;
  localparam logic POL_IDLE_LOW     = 1'b0;
  localparam logic TYPE_PULSE       = 1'b0;
  localparam logic TYPE_LEVEL       = 1'b1;

  // point table
  localparam int          NUM_POINTS = 20;
  localparam int          IDX_W      = 5;
  localparam logic [2:0]  ATTR_MAX   = 3'h6;
  localparam logic [2:0]  ATTR_RESET = 3'h0;
  localparam logic [31:0] TGT_RESET  = 32'h0000_0000;

  // pulse width limits, in ticks
  localparam logic [13:0] WIDTH_MIN = 14'h0001;
  localparam logic [13:0] WIDTH_MAX = 14'h2710;

  // timing: tick of 100 us at 4 ns clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_TIME_NS  = 100000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } run_state_type;

endpackage

/* File: point_table.sv */
// comparison point table: target position and attribute per point
// assumes a single writer on the core clock; read data lag address by one cycle
`timescale 1ns/1ns
module point_table
  import position_compare_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // write port
  input  wire logic                   wr_en,
  input  wire logic [IDX_W-1:0]       wr_index,
  input  wire logic [31:0]            wr_target,
  input  wire logic [2:0]             wr_attr,
  // read port
  input  wire logic [IDX_W-1:0]       rd_index,
  output logic      [31:0]            rd_target,
  output logic      [2:0]             rd_attr
);

  logic [31:0] target_q [NUM_POINTS];
  logic [2:0]  attr_q   [NUM_POINTS];

  // storage; attributes above the legal range are refused
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_POINTS; i++) begin
        target_q[i] <= TGT_RESET;
        attr_q[i]   <= ATTR_RESET;
      end
    end else if (wr_en && (int'(wr_index) < NUM_POINTS)) begin
      target_q[wr_index] <= wr_target;
      if (wr_attr <= ATTR_MAX) begin
        attr_q[wr_index] <= wr_attr;
      end
    end
  end

  // registered read, out-of-range index reads zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_target <= TGT_RESET;
      rd_attr   <= ATTR_RESET;
    end else if (int'(rd_index) < NUM_POINTS) begin
      rd_target <= target_q[rd_index];
      rd_attr   <= attr_q[rd_index];
    end else begin
      rd_target <= TGT_RESET;
      rd_attr   <= ATTR_RESET;
    end
  end

  // no stored attribute leaves the legal range
  property p_attr;
    @(posedge clk_sys) disable iff (reset) rd_attr <= ATTR_MAX;
  endproperty
  a_attr: assert property (p_attr) else $error("point attribute out of range");

endmodule

/* File: position_compare_output.sv */
// position compare output unit: scaled position count, point sequencer, output shaper
// assumes objects and encoder delta come from logic on clk_sys, so no synchronisers
`timescale 1ns/1ns
module position_compare_output
  import position_compare_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)(
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  // host control objects
  input  wire logic [15:0]                 compare_control_word,
  input  wire logic [15:0]                 position_adjust_value,
  // host settings
  input  wire logic [31:0]                 position_scale_setting,
  input  wire logic [31:0]                 encoder_counts_per_rev,
  input  wire logic                        abs_inc_mode_field,
  input  wire logic                        single_cyclic_field,
  input  wire logic                        output_polarity_setting,
  input  wire logic                        output_type_setting,
  input  wire logic [13:0]                 pulse_width_setting,
  input  wire logic [15:0]                 delay_compensation_time,
  input  wire logic [31:0]                 origin_bias_value,
  input  wire logic [IDX_W-1:0]            point_count,
  // point table write
  input  wire logic                        point_wr_en,
  input  wire logic [IDX_W-1:0]            point_wr_index,
  input  wire logic [31:0]                 point_wr_target,
  input  wire logic [2:0]                  point_wr_attr,
  // encoder
  input  wire logic signed [15:0]          encoder_delta,
  // status and monitors
  output logic      [15:0]                 compare_status_word,
  output logic      [15:0]                 current_point_index,
  output logic      [31:0]                 current_position,
  output logic      [2:0]                  current_point_attr,
  // terminal output
  output logic                             compare_digital_output
);
  import position_compare_pkg::*;

  typedef struct packed {
    run_state_type      state;
    logic [2:0]         ctrl_prev;
    logic [IDX_W-1:0]   idx;
    logic               rd_wait;
    logic signed [31:0] pos;
    logic signed [47:0] acc;
    logic               origin_done;
    logic               adj_done;
    logic               active;
    logic               out;
    logic [19:0]        pcnt;
    logic [13:0]        wcnt;
    logic               prev_valid;
    logic               prev_neg;
    logic [19:0]        scnt;
    logic signed [31:0] win_start;
    logic signed [31:0] speed;
  } state_type;

  state_type q;
  state_type d;

  logic [31:0]        tgt;
  logic signed [47:0] prod;
  logic signed [47:0] acc_sum;
  logic signed [47:0] res;
  logic signed [47:0] lead_full;
  logic signed [31:0] pred;
  logic signed [31:0] diff;
  logic               hit;
  logic               last;
  logic [13:0]        width_cl;
  logic [IDX_W-1:0]   last_idx;
  logic               en_rise;
  logic               or_rise;
  logic               adj_rise;

  point_table u_points (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .wr_en     (point_wr_en),
    .wr_index  (point_wr_index),
    .wr_target (point_wr_target),
    .wr_attr   (point_wr_attr),
    .rd_index  (q.idx),
    .rd_target (tgt),
    .rd_attr   (current_point_attr)
  );

  // edge detect on control bits
  assign en_rise  = compare_control_word[BIT_ENABLE] & ~q.ctrl_prev[BIT_ENABLE];
  assign or_rise  = compare_control_word[BIT_ORIGIN] & ~q.ctrl_prev[BIT_ORIGIN];
  assign adj_rise = compare_control_word[BIT_ADJUST] & ~q.ctrl_prev[BIT_ADJUST];

  // fractional scaling; operands widened first so the product keeps all its bits
  assign prod    = 48'(encoder_delta) * 48'($signed({1'b0, position_scale_setting}));
  assign acc_sum = q.acc + prod;
  assign res     = (encoder_counts_per_rev == 32'h0) ? 48'sh1 : $signed({16'h0, encoder_counts_per_rev});
  // prediction lead = counts per tick times compensation ticks, full width product
  assign lead_full = 48'(q.speed) * 48'($signed({1'b0, delay_compensation_time}));
  assign pred      = q.pos + lead_full[31:0];
  assign diff      = pred - $signed(tgt);
  // match on equality or a crossing of the target
  assign hit = (q.state == ST_RUN) && !q.rd_wait && ((diff == 32'sh0) || (q.prev_valid && (diff[31] != q.prev_neg)));
  // end of sequence; a count of zero is treated as one point
  assign last_idx = (point_count == '0) ? '0 : point_count - IDX_W'(1);
  assign last     = q.idx >= last_idx;
  // clamp width into its legal range
  assign width_cl = (pulse_width_setting < WIDTH_MIN) ? WIDTH_MIN :
                    (pulse_width_setting > WIDTH_MAX) ? WIDTH_MAX : pulse_width_setting;
  // next-state logic
  always_comb begin
    d           = q;
    d.ctrl_prev = compare_control_word[2:0];
    d.rd_wait   = 1'b0;
    // at most one scaled count per step, remainder kept in the accumulator
    d.acc = acc_sum;
    if (acc_sum >= res) begin
      d.acc = acc_sum - res;
      d.pos = q.pos + 32'sh1;
    end else if (acc_sum <= -res) begin
      d.acc = acc_sum + res;
      d.pos = q.pos - 32'sh1;
    end
    // speed sampled once per tick for the early-output lead
    d.scnt = q.scnt + 20'h1;
    if (q.scnt == 20'(TICK_CYC - 1)) begin
      d.scnt      = 20'h0;
      d.speed     = q.pos - q.win_start;
      d.win_start = q.pos;
    end
    // pulse timing in ticks, restarted by each match
    if (q.active && (output_type_setting == TYPE_PULSE)) begin
      d.pcnt = q.pcnt + 20'h1;
      if (q.pcnt == 20'(TICK_CYC - 1)) begin
        d.pcnt = 20'h0;
        d.wcnt = q.wcnt - 14'h1;
        if (q.wcnt <= WIDTH_MIN) begin
          d.active = 1'b0;
        end
      end
    end
    if (hit) begin
      d.prev_valid = 1'b0;
      d.rd_wait    = 1'b1;
      // incremental mode counts afresh; absolute keeps the count
      if (abs_inc_mode_field == MODE_INCREMENTAL) begin
        d.pos = 32'sh0;
        d.acc = 48'sh0;
      end
      // pulse restarts its width, level toggles
      if (output_type_setting == TYPE_PULSE) begin
        d.active = 1'b1;
        d.wcnt   = width_cl;
        d.pcnt   = 20'h0;
      end else begin
        d.active = ~q.active;
      end
      // advance point; cyclic wraps; single stops
      if (!last) begin
        d.idx = q.idx + IDX_W'(1);
      end else if (single_cyclic_field == RUN_CYCLIC) begin
        d.idx = '0;
      end else begin
        d.state = ST_IDLE;
      end
    end else if ((q.state == ST_RUN) && !q.rd_wait) begin
      d.prev_valid = 1'b1;
      d.prev_neg   = diff[31];
    end
    if (!compare_control_word[BIT_ENABLE]) begin
      d.state      = ST_IDLE;
      d.active     = 1'b0;
      d.prev_valid = 1'b0;
      d.idx        = '0;
    end else if (en_rise) begin
      d.state      = ST_RUN;
      d.idx        = '0;
      d.rd_wait    = 1'b1;
    end
    // adjust adds on top of this cycle's count; done bit follows the host
    if (adj_rise) begin
      d.pos      = d.pos + 32'($signed(position_adjust_value));
      d.adj_done = 1'b1;
    end else if (!compare_control_word[BIT_ADJUST]) begin
      d.adj_done = 1'b0;
    end
    // origin load has the last word on the count; done bit follows the host
    if (or_rise) begin
      d.pos         = $signed(origin_bias_value);
      d.acc         = 48'sh0;
      d.origin_done = 1'b1;
    end else if (!compare_control_word[BIT_ORIGIN]) begin
      d.origin_done = 1'b0;
    end
    // polarity applied at the pin register
    d.out = output_polarity_setting ^ d.active;
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q <= '0; // idle state encodes as zero
    end else begin
      q <= d;
    end
  end

  assign compare_status_word    = {13'h0, q.adj_done, q.origin_done, q.state == ST_RUN};
  assign current_point_index    = 16'(q.idx);
  assign current_position       = q.pos;
  assign compare_digital_output = q.out;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  property p_start;
    $rose(compare_control_word[BIT_ENABLE]) |=> compare_status_word[BIT_ENABLE] && (current_point_index == 16'h0);
  endproperty
  a_start: assert property (p_start) else $error("enable edge did not start at first point");
  property p_stop;
    !compare_control_word[BIT_ENABLE] |=> !compare_status_word[BIT_ENABLE] && !q.active;
  endproperty
  a_stop: assert property (p_stop) else $error("enable low did not stop comparing");
  property p_idle_level;
    (!compare_control_word[BIT_ENABLE] && $stable(output_polarity_setting)) [*2]
      |-> compare_digital_output == output_polarity_setting;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level does not follow polarity");
  property p_pulse_len;
    ($fell(q.active) && compare_control_word[BIT_ENABLE] && (output_type_setting == TYPE_PULSE))
      |-> ($past(q.pcnt) == 20'(TICK_CYC - 1)) && ($past(q.wcnt) == WIDTH_MIN);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse ended before its width");
  property p_origin;
    $rose(compare_control_word[BIT_ORIGIN]) |=> compare_status_word[BIT_ORIGIN] &&
      (current_position == $past(origin_bias_value));
  endproperty
  a_origin: assert property (p_origin) else $error("origin load or done bit wrong");
  property p_origin_clear;
    !compare_control_word[BIT_ORIGIN] |=> !compare_status_word[BIT_ORIGIN];
  endproperty
  a_origin_clear: assert property (p_origin_clear) else $error("origin done not cleared");
  property p_adjust;
    $rose(compare_control_word[BIT_ADJUST]) |=> compare_status_word[BIT_ADJUST];
  endproperty
  a_adjust: assert property (p_adjust) else $error("adjust done not set");
  property p_adjust_clear;
    !compare_control_word[BIT_ADJUST] |=> !compare_status_word[BIT_ADJUST];
  endproperty
  a_adjust_clear: assert property (p_adjust_clear) else $error("adjust done not cleared");
  property p_single_end;
    (hit && last && (single_cyclic_field == RUN_SINGLE) && compare_control_word[BIT_ENABLE] &&
      !en_rise) |=> !compare_status_word[BIT_ENABLE];
  endproperty
  a_single_end: assert property (p_single_end) else $error("single run did not stop at end");
  property p_cyclic_end;
    (hit && last && (single_cyclic_field == RUN_CYCLIC) && compare_control_word[BIT_ENABLE])
      |=> compare_status_word[BIT_ENABLE] && (current_point_index == 16'h0);
  endproperty
  a_cyclic_end: assert property (p_cyclic_end) else $error("cyclic run did not wrap");
  property p_advance;
    (hit && !last && compare_control_word[BIT_ENABLE] && !en_rise)
      |=> current_point_index == $past(current_point_index) + 16'h1;
  endproperty
  a_advance: assert property (p_advance) else $error("match did not advance point");
  property p_incremental;
    (hit && (abs_inc_mode_field == MODE_INCREMENTAL) && !or_rise && !adj_rise) |=> current_position == 32'h0;
  endproperty
  a_incremental: assert property (p_incremental) else $error("incremental count not zeroed");

endmodule

/* File: terminal_receiver.sv */
// far-side terminal model: watches the compare output pin and measures it
// assumes a push-pull pin sampled on clk_sys; the terminal never drives back
`timescale 1ns/1ns
module terminal_receiver (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // observed pin and the idle level it should rest at
  input  wire logic        pin_level,
  input  wire logic        idle_level,
  // measurements for the bench
  output logic      [15:0] edge_count_q,
  output logic      [31:0] active_width_q
);
  logic        prev_q;
  logic [31:0] run_q;

  // count transitions and time each active stretch; the bench works on deltas,
  // so the settling step right after reset does not need masking here
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prev_q         <= 1'b0;
      run_q          <= 32'h0;
      edge_count_q   <= 16'h0;
      active_width_q <= 32'h0;
    end else begin
      prev_q <= pin_level;
      if (pin_level !== prev_q) begin
        edge_count_q <= edge_count_q + 16'h1;
      end
      if (pin_level !== idle_level) begin
        run_q <= run_q + 32'h1;
      end else if (run_q != 32'h0) begin
        active_width_q <= run_q; // latched when the pin returns to idle
        run_q          <= 32'h0;
      end
    end
  end
endmodule

/* File: position_compare_output_tb_top.sv */
// self-checking bench of the position compare output unit
// assumes the design package is compiled first and a short tick parameter
`timescale 1ns/1ns
`define CHECK(nm, ex, got) check_val(nm, 32'(ex), 32'(got))
module position_compare_output_tb_top;
  import position_compare_pkg::*;
  localparam int TICK = 10;
  logic              clk_sys   = 1'b0;
  logic              reset     = 1'b1;
  logic [15:0]       ctrl      = 16'h0;
  logic [15:0]       adj_val   = 16'h0;
  logic              abs_inc   = 1'b0;
  logic              cyclic    = 1'b0;
  logic              pol       = 1'b0;
  logic              otype     = 1'b0;
  logic [13:0]       width     = 14'h1;
  logic [31:0]       bias      = 32'h0;
  logic [IDX_W-1:0]  pcount    = 5'h1;
  logic              wr_en     = 1'b0;
  logic [IDX_W-1:0]  wr_idx    = 5'h0;
  logic [31:0]       wr_tgt    = 32'h0;
  logic [2:0]        wr_attr   = 3'h0;
  logic signed [15:0] delta    = 16'sh0;
  logic [15:0]       comp      = 16'h0;
  logic [15:0]       status;
  logic [15:0]       index;
  logic [31:0]       pos;
  logic [2:0]        attr;
  logic              dout;
  logic [15:0]       edges;
  logic [31:0]       act_w;
  logic [15:0]       rnd       = 16'h79a3;
  logic [15:0]       e0;
  logic [31:0]       base;
  int                bad_count    = 0;
  int                total_checks = 0;

  always #2 clk_sys = ~clk_sys;

  // device under test; scale 1 against 2 encoder counts gives one count per two moves
  position_compare_output #(.TICK_CYC(TICK)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .compare_control_word(ctrl), .position_adjust_value(adj_val),
    .position_scale_setting(32'h1), .encoder_counts_per_rev(32'h2), .abs_inc_mode_field(abs_inc),
    .single_cyclic_field(cyclic), .output_polarity_setting(pol), .output_type_setting(otype),
    .pulse_width_setting(width), .delay_compensation_time(comp), .origin_bias_value(bias),
    .point_count(pcount), .point_wr_en(wr_en), .point_wr_index(wr_idx), .point_wr_target(wr_tgt),
    .point_wr_attr(wr_attr), .encoder_delta(delta), .compare_status_word(status),
    .current_point_index(index), .current_position(pos), .current_point_attr(attr),
    .compare_digital_output(dout));

  // far-side terminal watching the pin
  terminal_receiver term_u (.clk_sys(clk_sys), .reset(reset), .pin_level(dout), .idle_level(pol),
    .edge_count_q(edges), .active_width_q(act_w));

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [15:0] exp_status(input logic run, input logic org, input logic adj);
    return {13'h0, adj, org, run};
  endfunction

  // inputs always change 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic check_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic write_point(input int i, input logic [31:0] t, input logic [2:0] a);
    wr_idx  = 5'(i);
    wr_tgt  = t;
    wr_attr = a;
    wr_en   = 1'b1;
    step(1);
    wr_en   = 1'b0;
    step(1);
  endtask

  // move forward until the point index moves or the run ends, bounded
  task automatic advance();
    logic [15:0] old;
    int          n;
    old   = index;
    n     = 0;
    delta = 16'sh1;
    while (index === old && status[0] === 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    delta = 16'sh0;
    if (n >= 300) begin
      bad_count++;
      $display("mismatch advance expected match seen none");
    end
  endtask

  task automatic origin_load(input logic [31:0] b);
    bias    = b;
    ctrl[1] = 1'b1;
    step(2);
    `CHECK("pos_origin", b, pos);
    `CHECK("status_origin", exp_status(0, 1, 0), status);
    ctrl[1] = 1'b0;
    step(2);
    `CHECK("status_origin_clr", 16'h0, status);
  endtask

  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    step(2);
    `CHECK("status_reset", 16'h0, status);
    `CHECK("idle_reset", pol, dout);
    rnd = lfsr_next(rnd);
    origin_load({24'h0, rnd[7:0]});
    // one-shot adjust with a signed random step
    adj_val = {{8{rnd[15]}}, rnd[15:8]};
    ctrl[2] = 1'b1;
    step(2);
    `CHECK("pos_adjust", bias + {{16{adj_val[15]}}, adj_val}, pos);
    `CHECK("status_adjust", exp_status(0, 0, 1), status);
    ctrl[2] = 1'b0;
    step(2);
    `CHECK("status_adjust_clr", 16'h0, status);
    // forty moves at one half count each
    base  = pos;
    delta = 16'sh1;
    step(40);
    delta = 16'sh0;
    step(2);
    `CHECK("pos_scale", base + 32'd20, pos);
    // single absolute pulse run over three points
    rnd   = lfsr_next(rnd);
    pol   = rnd[0];
    width = 14'(1 + rnd[1]);
    base  = pos;
    for (int i = 0; i < 3; i++) write_point(i, base + 32'(10 * (i + 1)), 3'h0);
    pcount = 5'h3;
    step(2);
    `CHECK("idle_pol", pol, dout);
    e0      = edges;
    ctrl[0] = 1'b1;
    step(2);
    `CHECK("status_run", exp_status(1, 0, 0), status);
    `CHECK("index_start", 16'h0, index);
    for (int m = 0; m < 3; m++) begin
      advance();
      step(int'(width) * TICK + 4);
      `CHECK("pulse_width", int'(width) * TICK, act_w);
      `CHECK("pos_kept", pos >= base + 32'(10 * (m + 1)), 1'b1);
      if (m < 2) `CHECK("index_next", m + 1, index);
    end
    `CHECK("single_end", 1'b0, status[0]);
    `CHECK("pulse_edges", 16'h6, edges - e0);
    `CHECK("idle_after", pol, dout);
    step(5);
    `CHECK("single_no_restart", 1'b0, status[0]);
    ctrl[0] = 1'b0;
    step(2);
    // cyclic incremental level run over two points
    rnd = lfsr_next(rnd);
    pol = rnd[0];
    origin_load(32'h0);
    write_point(0, 32'd10, 3'h6);
    write_point(1, 32'd10, 3'h7);
    pcount  = 5'h2;
    abs_inc = 1'b1;
    cyclic  = 1'b1;
    otype   = 1'b1;
    step(2);
    e0      = edges;
    ctrl[0] = 1'b1;
    step(3);
    `CHECK("attr_first", 3'h6, attr);
    for (int m = 0; m < 4; m++) begin
      advance();
      step(2);
      `CHECK("index_wrap", (m + 1) % 2, index);
      `CHECK("cyclic_run", 1'b1, status[0]);
      `CHECK("pos_reset", pos <= 32'd2, 1'b1);
      `CHECK("level_edges", m + 1, edges - e0);
      if (m == 0) `CHECK("attr_refused", 3'h0, attr);
    end
    ctrl[0] = 1'b0;
    step(2);
    `CHECK("status_stop", 16'h0, status);
    `CHECK("index_stop", 16'h0, index);
    `CHECK("idle_stop", pol, dout);
    // early output: one tick of lead at half a count per cycle fires TICK/2 counts early
    comp    = 16'h1;
    abs_inc = 1'b0;
    cyclic  = 1'b0;
    otype   = 1'b0;
    base    = pos;
    write_point(0, base + 32'd40, 3'h0);
    pcount  = 5'h1;
    ctrl[0] = 1'b1;
    step(2);
    advance();
    `CHECK("pos_early", base + 32'd40 - 32'(TICK / 2 * int'(comp)), pos);
    `CHECK("early_single_end", 1'b0, status[0]);
    ctrl[0] = 1'b0;
    step(2);
    report_and_stop();
  end
endmodule
